// file: mcm_pkg.sv
// Shared constants and types for the modem control and mode register pair.
// Assumes one 200 MHz clock and a synchronous active-low reset at both ends.
// Functional notes
// - Filter band from rate and high-bandwidth bits
// - Level response select applies in receive only
// - Level acquire overrides programmed level response
// - Loop bandwidth select applies in receive only
// - Bit clock acquire overrides programmed loop bandwidth
// - Host normally programs averaging, hold on fades
// - Mode register is eight bits, write only
// - Interrupt pin low while enabled and pending
// - Invert bit flips transmit and receive data
// - Direction bit one transmits, zero receives
// - Host waits two bit-times after entering transmit
// - Direction change cancels the current task
// - Scrambler runs only in listed tasks, enabled
// - Host keeps scrambler bit during data blocks
// - Powersave bit disables filters, extraction, output buffer
// - Host waits two bit-times after leaving powersave
// - Quality reading sets request bit when enabled, in receive only
// - High crystal drive is a static output
// - Status register is readable outside settling waits; the host holds off all reads and writes during settling waits
// - Control register is eight bits, write only
// - Status read clears the interrupt request bit
package mcm_pkg;
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_MODE = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Control register fields.
  localparam int CTL_RATE_BAND = 4;
  localparam int CTL_LEVEL_HI = 3;
  localparam int CTL_LEVEL_LO = 2;
  localparam int CTL_LOOP_HI = 1;
  localparam int CTL_LOOP_LO = 0;
  // Mode register fields.
  localparam int MODE_IRQ_EN = 7;
  localparam int MODE_INVERT = 6;
  localparam int MODE_DIRECTION = 5;
  localparam int MODE_SCRAMBLE = 4;
  localparam int MODE_POWERSAVE = 3;
  localparam int MODE_QUALITY_EN = 2;
  localparam int MODE_XTAL_DRIVE = 1;
  localparam int MODE_HIGH_BW = 0;
  // Status register fields.
  localparam int STAT_IRQ = 7;
  localparam int STAT_QUALITY = 2;
  // Bit time at the default 9600 bit/s rate, and the settling wait of two bit-times.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BIT_TIME_PS = 104166667;
  localparam int SETTLE_BITS = 2;
  localparam int SETTLE_CYCLES = (SETTLE_BITS * (BIT_TIME_PS / CLK_PERIOD_PS));
  typedef enum logic [2:0] {
    TASK_IDLE = 3'b000,
    TASK_TSO = 3'b001,
    TASK_RDB = 3'b010,
    TASK_TDB = 3'b011,
    TASK_RSD = 3'b100,
    TASK_TSD = 3'b101,
    TASK_OTHER = 3'b110
  } mcm_task_type;
  typedef enum logic [1:0] {
    LEVEL_HOLD = 2'b00,
    LEVEL_PEAK_AVG = 2'b01,
    LEVEL_PEAK_DET = 2'b10,
    LEVEL_LOSSY = 2'b11
  } mcm_level_type;
  typedef enum logic [1:0] {
    LOOP_HOLD = 2'b00,
    LOOP_NARROW = 2'b01,
    LOOP_MEDIUM = 2'b10,
    LOOP_WIDE = 2'b11
  } mcm_loop_type;
  typedef enum logic [1:0] {
    BAND_LOW = 2'b00,
    BAND_RESERVED = 2'b01,
    BAND_MID = 2'b10,
    BAND_HIGH = 2'b11
  } mcm_band_type;
endpackage

// file: mcm_port_if.sv
// Parallel host port between the modem register bank and its host.
// The interrupt line is open drain with a pull-up modelled here.
`timescale 1ns/1ps
`default_nettype none
interface mcm_port_if;
  logic wr_en;
  logic rd_en;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic interrupt_pin_n_out;
  logic interrupt_pin_n_oe;
  wire interrupt_pin_n;
  assign interrupt_pin_n = interrupt_pin_n_oe ? interrupt_pin_n_out : 1'b1;
  modport dev (
    input wr_en, rd_en, addr, wdata,
    output rdata, interrupt_pin_n_out, interrupt_pin_n_oe
  );
  modport host (
    output wr_en, rd_en, addr, wdata,
    input rdata, interrupt_pin_n
  );
endinterface
`default_nettype wire

// file: mcm_device.sv
// Modem end: control and mode registers, status register and the static
// configuration they drive into the modem core.
// Assumes the host port signals are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module mcm_device (
  input wire logic mclk,
  input wire logic rstn,
  mcm_port_if.dev port,
  input wire mcm_pkg::mcm_task_type active_task,
  input wire logic level_acquire_command,
  input wire logic bit_clock_acquire_command,
  input wire mcm_pkg::mcm_level_type level_acquire_setting,
  input wire mcm_pkg::mcm_loop_type loop_acquire_setting,
  input wire logic quality_done,
  input wire logic quality_read,
  input wire logic core_irq_event,
  input wire logic [7:0] core_status,
  input wire logic tx_bit_in,
  input wire logic rx_bit_in,
  output logic tx_bit_out,
  output logic rx_bit_out,
  output mcm_pkg::mcm_band_type filter_band,
  output mcm_pkg::mcm_level_type level_response_select,
  output mcm_pkg::mcm_loop_type loop_bandwidth_select,
  output logic transmit_mode,
  output logic task_cancel,
  output logic scrambler_run,
  output logic powersave_bit,
  output logic filters_enable,
  output logic extraction_enable,
  output logic transmit_buffer_enable,
  output logic high_crystal_drive,
  output logic data_invert
);
  logic [7:0] control_q;
  logic [7:0] mode_q;
  logic irq_q;
  logic quality_ready_q;
  logic [7:0] rdata_q;
  logic task_cancel_q;
  logic tx_bit_q;
  logic rx_bit_q;
  logic wr_control;
  logic wr_mode;
  logic rd_status;
  logic irq_set;
  logic quality_set;
  mcm_pkg::mcm_level_type level_prog;
  mcm_pkg::mcm_loop_type loop_prog;

  assign wr_control = port.wr_en && (port.addr == mcm_pkg::ADDR_CONTROL);
  assign wr_mode = port.wr_en && (port.addr == mcm_pkg::ADDR_MODE);
  assign rd_status = port.rd_en && (port.addr == mcm_pkg::ADDR_STATUS);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      control_q <= mcm_pkg::REG_RESET;
    end else if (wr_control) begin
      control_q <= port.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode_q <= mcm_pkg::REG_RESET;
    end else if (wr_mode) begin
      mode_q <= port.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      task_cancel_q <= 1'b0;
    end else begin
      task_cancel_q <= wr_mode &&
        (port.wdata[mcm_pkg::MODE_DIRECTION] != mode_q[mcm_pkg::MODE_DIRECTION]);
    end
  end
  assign task_cancel = task_cancel_q;

  assign transmit_mode = mode_q[mcm_pkg::MODE_DIRECTION];

  assign quality_set = quality_done && !transmit_mode;
  assign irq_set = core_irq_event ||
    (quality_set && mode_q[mcm_pkg::MODE_QUALITY_EN]);

  // clear on status read
  // A new event in the read cycle wins, so it is never lost.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else if (irq_set) begin
      irq_q <= 1'b1;
    end else if (rd_status) begin
      irq_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      quality_ready_q <= 1'b0;
    end else if (quality_set) begin
      quality_ready_q <= 1'b1;
    end else if (quality_read) begin
      quality_ready_q <= 1'b0;
    end
  end

  // mode and control never read back
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (rd_status) begin
      rdata_q <= core_status;
      rdata_q[mcm_pkg::STAT_IRQ] <= irq_q;
      rdata_q[mcm_pkg::STAT_QUALITY] <= quality_ready_q;
    end else if (port.rd_en) begin
      rdata_q <= 8'h00;
    end
  end
  assign port.rdata = rdata_q;

  assign port.interrupt_pin_n_out = 1'b0;
  assign port.interrupt_pin_n_oe = mode_q[mcm_pkg::MODE_IRQ_EN] && irq_q;

  assign filter_band = mcm_pkg::mcm_band_type'({control_q[mcm_pkg::CTL_RATE_BAND],
                                                 mode_q[mcm_pkg::MODE_HIGH_BW]});

  assign level_prog = mcm_pkg::mcm_level_type'(
    control_q[mcm_pkg::CTL_LEVEL_HI:mcm_pkg::CTL_LEVEL_LO]);
  assign loop_prog = mcm_pkg::mcm_loop_type'(
    control_q[mcm_pkg::CTL_LOOP_HI:mcm_pkg::CTL_LOOP_LO]);

  // The programmed setting is untouched by an acquisition, so it returns
  // by itself once the command drops.
  always_comb begin
    if (transmit_mode) begin
      level_response_select = mcm_pkg::LEVEL_HOLD;
    end else if (level_acquire_command) begin
      level_response_select = level_acquire_setting;
    end else begin
      level_response_select = level_prog;
    end
  end

  always_comb begin
    if (transmit_mode) begin
      loop_bandwidth_select = mcm_pkg::LOOP_HOLD;
    end else if (bit_clock_acquire_command) begin
      loop_bandwidth_select = loop_acquire_setting;
    end else begin
      loop_bandwidth_select = loop_prog;
    end
  end

  always_comb begin
    unique case (active_task)
      mcm_pkg::TASK_TSO, mcm_pkg::TASK_RDB, mcm_pkg::TASK_TDB,
      mcm_pkg::TASK_RSD, mcm_pkg::TASK_TSD: begin
        scrambler_run = mode_q[mcm_pkg::MODE_SCRAMBLE];
      end
      default: begin
        scrambler_run = 1'b0;
      end
    endcase
  end

  assign powersave_bit = mode_q[mcm_pkg::MODE_POWERSAVE];
  assign filters_enable = !powersave_bit;
  assign extraction_enable = !powersave_bit;
  assign transmit_buffer_enable = !powersave_bit;

  assign high_crystal_drive = mode_q[mcm_pkg::MODE_XTAL_DRIVE];

  assign data_invert = mode_q[mcm_pkg::MODE_INVERT];
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_bit_q <= 1'b0;
      rx_bit_q <= 1'b0;
    end else begin
      tx_bit_q <= tx_bit_in ^ data_invert;
      rx_bit_q <= rx_bit_in ^ data_invert;
    end
  end
  assign tx_bit_out = tx_bit_q;
  assign rx_bit_out = rx_bit_q;
endmodule
`default_nettype wire

// file: mcm_host.sv
// Host end: turns user register commands into single-cycle port accesses,
// keeps the settling waits and refuses unsafe scrambler changes.
// Assumes the device answers a read one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module mcm_host #(
  parameter int SETTLE = mcm_pkg::SETTLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  mcm_port_if.host port,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [1:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic data_block_busy,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic interrupt_pending
);
  logic [31:0] wait_q;
  logic [7:0] mode_shadow_q;
  logic wr_q;
  logic rd_q;
  logic [1:0] addr_q;
  logic [7:0] wdata_q;
  logic rd_wait_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic scramble_block;
  logic take;
  logic enter_settle;

  assign scramble_block = cmd_write && (cmd_addr == mcm_pkg::ADDR_MODE) && data_block_busy &&
    (cmd_wdata[mcm_pkg::MODE_SCRAMBLE] != mode_shadow_q[mcm_pkg::MODE_SCRAMBLE]);
  assign cmd_ready = (wait_q == 32'h0) && !scramble_block && !rd_q;
  assign take = cmd_valid && cmd_ready;

  assign enter_settle = take && cmd_write && (cmd_addr == mcm_pkg::ADDR_MODE) &&
    ((cmd_wdata[mcm_pkg::MODE_DIRECTION] && !mode_shadow_q[mcm_pkg::MODE_DIRECTION]) ||
     (!cmd_wdata[mcm_pkg::MODE_POWERSAVE] && mode_shadow_q[mcm_pkg::MODE_POWERSAVE]));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wait_q <= 32'h0;
    end else if (enter_settle) begin
      wait_q <= 32'(SETTLE);
    end else if (wait_q != 32'h0) begin
      wait_q <= wait_q - 32'h1;
    end
  end

  // The mode register cannot be read back, so its last write is mirrored.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode_shadow_q <= mcm_pkg::REG_RESET;
    end else if (take && cmd_write && (cmd_addr == mcm_pkg::ADDR_MODE)) begin
      mode_shadow_q <= cmd_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 2'h0;
      wdata_q <= 8'h00;
    end else begin
      wr_q <= take && cmd_write;
      rd_q <= take && !cmd_write;
      if (take) begin
        addr_q <= cmd_addr;
        wdata_q <= cmd_wdata;
      end
    end
  end
  assign port.wr_en = wr_q;
  assign port.rd_en = rd_q;
  assign port.addr = addr_q;
  assign port.wdata = wdata_q;

  // The device loads its read data on the strobe edge, so it is taken one edge later.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_wait_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      rd_wait_q <= rd_q;
      rsp_valid_q <= rd_wait_q;
      if (rd_wait_q) begin
        rsp_data_q <= port.rdata;
      end
    end
  end
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign interrupt_pending = !port.interrupt_pin_n;
endmodule
`default_nettype wire

// file: mcm_port_sva.sv
// Checker for the host port between the modem register pair and its host.
// Assumes the bench instantiates it beside the interface joining both ends.
`timescale 1ns/1ps
`default_nettype none
module mcm_port_sva #(
  parameter int SETTLE = mcm_pkg::SETTLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic interrupt_pin_n_out,
  input wire logic interrupt_pin_n_oe,
  input wire logic interrupt_pin_n
);
  logic [7:0] mode_q;
  int cnt_q;
  logic mw;
  assign mw = wr_en && addr == mcm_pkg::ADDR_MODE;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode_q <= 8'h00;
    end else if (mw) begin
      mode_q <= wdata;
    end
  end
  // One cycle is left as slack so the host may take its next request early.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= 0;
    end else if (mw &&
        ((wdata[mcm_pkg::MODE_DIRECTION] && !mode_q[mcm_pkg::MODE_DIRECTION]) ||
         (mode_q[mcm_pkg::MODE_POWERSAVE] && !wdata[mcm_pkg::MODE_POWERSAVE]))) begin
      cnt_q <= SETTLE - 1;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_ctl_zero;
    rd_en && addr == mcm_pkg::ADDR_CONTROL |=> rdata == 8'h00;
  endproperty
  a_ctl_zero: assert property (p_ctl_zero)
    else $error("control read returned data");
  property p_mode_zero;
    rd_en && addr == mcm_pkg::ADDR_MODE |=> rdata == 8'h00;
  endproperty
  a_mode_zero: assert property (p_mode_zero)
    else $error("mode read returned data");
  property p_en_off;
    mw && !wdata[7] |=> !interrupt_pin_n_oe;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("interrupt line driven while disabled");
  property p_pin;
    interrupt_pin_n_oe |-> !interrupt_pin_n && !interrupt_pin_n_out;
  endproperty
  a_pin: assert property (p_pin)
    else $error("interrupt line not low");
  property p_reset;
    $rose(rstn) |-> rdata == 8'h00 && !interrupt_pin_n_oe;
  endproperty
  a_reset: assert property (p_reset)
    else $error("port not cleared by reset");
  property p_hold;
    !rd_en |=> $stable(rdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data changed without a read");
  property p_irq_stat;
    interrupt_pin_n_oe && rd_en && addr == mcm_pkg::ADDR_STATUS |=> rdata[7];
  endproperty
  a_irq_stat: assert property (p_irq_stat)
    else $error("line low but request bit clear");
  property p_settle;
    cnt_q != 0 |-> !wr_en && !rd_en;
  endproperty
  a_settle: assert property (p_settle)
    else $error("access during settling wait");
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench joining host and modem register ends.
// Assumes one 200 MHz clock and a short settle parameter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %0t %h %h", $time, (a), (e)); end end
module tb_top;
  logic mclk, rstn, level_acquire_command, bit_clock_acquire_command;
  mcm_pkg::mcm_task_type active_task;
  mcm_pkg::mcm_level_type level_acquire_setting, level_response_select;
  mcm_pkg::mcm_loop_type loop_acquire_setting, loop_bandwidth_select;
  mcm_pkg::mcm_band_type filter_band;
  logic quality_done, quality_read, core_irq_event, tx_bit_in, rx_bit_in, tx_bit_out;
  logic rx_bit_out, transmit_mode, task_cancel, scrambler_run, powersave_bit;
  logic filters_enable, extraction_enable, transmit_buffer_enable, high_crystal_drive;
  logic data_invert, cmd_valid, cmd_write, data_block_busy, cmd_ready, rsp_valid;
  logic interrupt_pending, irq_m, dq_m;
  logic [7:0] core_status, cmd_wdata, rsp_data, rexp;
  logic [1:0] cmd_addr;
  logic [7:0] exp_q[$];
  int num_errors, checked, seed, i, n;
  mcm_port_if u_mcm_port_if();
  mcm_device u_mcm_device (
    .mclk(mclk), .rstn(rstn), .port(u_mcm_port_if), .active_task(active_task),
    .level_acquire_command(level_acquire_command),
    .bit_clock_acquire_command(bit_clock_acquire_command),
    .level_acquire_setting(level_acquire_setting), .loop_acquire_setting(loop_acquire_setting),
    .quality_done(quality_done), .quality_read(quality_read), .core_irq_event(core_irq_event),
    .core_status(core_status), .tx_bit_in(tx_bit_in), .rx_bit_in(rx_bit_in),
    .tx_bit_out(tx_bit_out), .rx_bit_out(rx_bit_out), .filter_band(filter_band),
    .level_response_select(level_response_select), .loop_bandwidth_select(loop_bandwidth_select),
    .transmit_mode(transmit_mode), .task_cancel(task_cancel), .scrambler_run(scrambler_run),
    .powersave_bit(powersave_bit), .filters_enable(filters_enable),
    .extraction_enable(extraction_enable), .transmit_buffer_enable(transmit_buffer_enable),
    .high_crystal_drive(high_crystal_drive), .data_invert(data_invert)
  );
  mcm_host #(.SETTLE(8)) u_mcm_host (
    .mclk(mclk), .rstn(rstn), .port(u_mcm_port_if), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .data_block_busy(data_block_busy), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .interrupt_pending(interrupt_pending)
  );
  mcm_port_sva #(.SETTLE(8)) u_mcm_port_sva (
    .mclk(mclk),
    .rstn(rstn),
    .wr_en(u_mcm_port_if.wr_en),
    .rd_en(u_mcm_port_if.rd_en),
    .addr(u_mcm_port_if.addr),
    .wdata(u_mcm_port_if.wdata),
    .rdata(u_mcm_port_if.rdata),
    .interrupt_pin_n_out(u_mcm_port_if.interrupt_pin_n_out),
    .interrupt_pin_n_oe(u_mcm_port_if.interrupt_pin_n_oe),
    .interrupt_pin_n(u_mcm_port_if.interrupt_pin_n)
  );
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task end_of_test;
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task tick;
    @(posedge mclk);
    #1;
  endtask
  function logic [7:0] st();
    return {irq_m, core_status[6:3], dq_m, core_status[1:0]};
  endfunction
  task cmd(input logic w, input logic [1:0] a, input logic [7:0] d);
    int k;
    k = 0;
    tick();
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    #1;
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(posedge mclk);
      #2;
      k++;
    end
    if (k == 100) begin
      num_errors++;
      end_of_test();
    end
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    tick();
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    cmd(1'b1, a, d);
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cmd(1'b0, a, 8'h00);
    if (a == mcm_pkg::ADDR_STATUS) begin
      irq_m = 1'b0;
    end
    repeat (3) tick();
  endtask
  always @(negedge mclk) begin
    if (rsp_valid === 1'b1) begin
      rexp = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
      `CHK(rsp_data, rexp)
    end
  end
  initial begin
    seed = 78;
    {rstn, level_acquire_command, bit_clock_acquire_command, quality_done} = 4'h0;
    {quality_read, core_irq_event, tx_bit_in, rx_bit_in} = 4'h0;
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata, data_block_busy} = 12'h000;
    {irq_m, dq_m, num_errors, checked} = 66'h0;
    active_task = mcm_pkg::TASK_IDLE;
    level_acquire_setting = mcm_pkg::LEVEL_PEAK_DET;
    loop_acquire_setting = mcm_pkg::LOOP_NARROW;
    core_status = 8'($random(seed));
    repeat (12) @(posedge mclk);
    #1 rstn = 1'b1;
    `CHK({filter_band, transmit_mode, powersave_bit, high_crystal_drive, data_invert}, 6'h00)
    rd(mcm_pkg::ADDR_STATUS, st());
    for (i = 0; i < 4; i++) begin
      wr(mcm_pkg::ADDR_CONTROL, {3'h0, i[1], 4'h0});
      wr(mcm_pkg::ADDR_MODE, {7'h00, i[0]});
      `CHK(filter_band, i[1:0])
    end
    wr(mcm_pkg::ADDR_CONTROL, 8'h04);
    `CHK(level_response_select, mcm_pkg::LEVEL_PEAK_AVG)
    wr(mcm_pkg::ADDR_CONTROL, 8'h00);
    `CHK(level_response_select, mcm_pkg::LEVEL_HOLD)
    for (i = 0; i < 16; i++) begin
      wr(mcm_pkg::ADDR_CONTROL, i[7:0]);
      `CHK({level_response_select, loop_bandwidth_select}, i[3:0])
    end
    level_acquire_command = 1'b1;
    tick();
    `CHK({level_response_select, loop_bandwidth_select}, 4'hb)
    level_acquire_command = 1'b0;
    bit_clock_acquire_command = 1'b1;
    tick();
    `CHK({level_response_select, loop_bandwidth_select}, 4'hd)
    bit_clock_acquire_command = 1'b0;
    tick();
    `CHK(loop_bandwidth_select, 2'h3)
    rd(mcm_pkg::ADDR_CONTROL, 8'h00);
    rd(mcm_pkg::ADDR_MODE, 8'h00);
    rd(2'h3, 8'h00);
    wr(mcm_pkg::ADDR_STATUS, 8'hff);
    wr(2'h3, 8'hff);
    `CHK({filter_band, data_invert, transmit_mode}, 4'h4)
    wr(mcm_pkg::ADDR_MODE, 8'h40);
    repeat (8) begin
      tx_bit_in = 1'($random(seed));
      rx_bit_in = 1'($random(seed));
      tick();
      `CHK({tx_bit_out, rx_bit_out}, ~{tx_bit_in, rx_bit_in})
    end
    for (i = 0; i < 2; i++) begin
      wr(mcm_pkg::ADDR_MODE, {2'h1, ~i[0], 5'h00});
      n = 0;
      repeat (3) begin
        n += int'(task_cancel === 1'b1);
        tick();
      end
      `CHK(n, 1)
      `CHK(transmit_mode, ~i[0])
      `CHK({level_response_select, loop_bandwidth_select}, i[0] ? 4'hf : 4'h0)
    end
    for (i = 0; i < 14; i++) begin
      if (i % 7 == 0) begin
        wr(mcm_pkg::ADDR_MODE, i == 0 ? 8'h10 : 8'h00);
      end
      active_task = mcm_pkg::mcm_task_type'(3'(i % 7));
      tick();
      `CHK(scrambler_run, i < 7 && i % 7 != 0 && i % 7 != 6)
    end
    `CHK({tx_bit_out, rx_bit_out}, {tx_bit_in, rx_bit_in})
    tick();
    data_block_busy = 1'b1;
    active_task = mcm_pkg::TASK_TDB;
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {2'h3, mcm_pkg::ADDR_MODE, 8'h10};
    repeat (4) tick();
    `CHK({cmd_ready, scrambler_run}, 2'h0)
    data_block_busy = 1'b0;
    tick();
    cmd_valid = 1'b0;
    tick();
    `CHK(scrambler_run, 1'b1)
    wr(mcm_pkg::ADDR_MODE, 8'h08);
    `CHK({powersave_bit, filters_enable, extraction_enable, transmit_buffer_enable}, 4'h8)
    wr(mcm_pkg::ADDR_MODE, 8'h02);
    `CHK({powersave_bit, filters_enable, transmit_buffer_enable, high_crystal_drive}, 4'h7)
    wr(mcm_pkg::ADDR_MODE, 8'h84);
    quality_done = 1'b1;
    tick();
    quality_done = 1'b0;
    {irq_m, dq_m} = 2'h3;
    tick();
    `CHK(interrupt_pending, 1'b1)
    rd(mcm_pkg::ADDR_STATUS, st());
    `CHK(interrupt_pending, 1'b0)
    rd(mcm_pkg::ADDR_STATUS, st());
    quality_read = 1'b1;
    tick();
    quality_read = 1'b0;
    dq_m = 1'b0;
    rd(mcm_pkg::ADDR_STATUS, st());
    wr(mcm_pkg::ADDR_MODE, 8'h04);
    core_irq_event = 1'b1;
    tick();
    core_irq_event = 1'b0;
    irq_m = 1'b1;
    tick();
    `CHK(interrupt_pending, 1'b0)
    wr(mcm_pkg::ADDR_MODE, 8'h84);
    `CHK(interrupt_pending, 1'b1)
    rd(mcm_pkg::ADDR_STATUS, st());
    wr(mcm_pkg::ADDR_MODE, 8'ha4);
    quality_done = 1'b1;
    tick();
    quality_done = 1'b0;
    tick();
    `CHK(interrupt_pending, 1'b0)
    rstn = 1'b0;
    repeat (2) tick();
    rstn = 1'b1;
    tick();
    `CHK({transmit_mode, level_response_select, loop_bandwidth_select}, 5'h00)
    {irq_m, dq_m} = 2'h0;
    rd(mcm_pkg::ADDR_STATUS, st());
    `CHK(exp_q.size(), 0)
    end_of_test();
  end
endmodule
`default_nettype wire
